/* File: core/iah_pkg.sv */
package iah_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS     = 5;
    localparam int T_ADDR_SETUP_NS   = 35;
    localparam int T_AS_HIGH_NS      = 40;
    localparam int T_AS_LOW_NS       = 40;
    localparam int T_DATA_HOLD_NS    = 25;
    localparam int ADDR_SETUP_CYC    = (T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AS_HIGH_CYC       = (T_AS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AS_LOW_CYC        = (T_AS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_HOLD_CYC     = (T_DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMEOUT_CYC_DEF   = 12800;
    localparam int CNT_W             = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // read widths
    localparam logic [1:0] WID_BYTE  = 2'h0;
    localparam logic [1:0] WID_DBL   = 2'h1;
    localparam logic [1:0] WID_QUAD  = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // line group and bus
    localparam int NUM_LINES         = 7;
    localparam int LINE_LO_DEF       = 1;
    localparam int LINE_HI_DEF       = 7;
    localparam int DATA_W            = 32;
    localparam logic [2:0] CODE_NONE = 3'h0;

    typedef enum logic [2:0] {
        IAH_IDLE, IAH_REQ, IAH_SETUP, IAH_WAIT_ACK, IAH_HOLD, IAH_GAP
    } iah_state_e;

endpackage : iah_pkg

/* File: core/iah_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module iah_sync #(
    parameter int          WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = din;
        sync_d = meta_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign dout = sync_q;

endmodule : iah_sync
`default_nettype wire

/* File: core/iah_handler.sv */
`timescale 1ns/10ps
`default_nettype none
module iah_handler
    import iah_pkg::*;
#(
    parameter int LINE_LO     = LINE_LO_DEF,
    parameter int LINE_HI     = LINE_HI_DEF,
    parameter int TIMEOUT_CYC = TIMEOUT_CYC_DEF
) (
    input  wire logic              MCLK,
    input  wire logic              RESET,
    // user side
    input  wire logic [7:1]        LINE_ENABLE,
    input  wire logic [1:0]        READ_WIDTH,
    output logic      [DATA_W-1:0] STATUS_ID,
    output logic      [2:0]        STATUS_LEVEL,
    output logic                   STATUS_VALID,
    output logic                   STATUS_ERROR,
    // requester side
    output logic                   BUS_REQ,
    input  wire logic              BUS_GRANT,
    output logic                   BUS_DONE,
    // backplane pins
    input  wire logic [7:1]        IRQ_N,
    input  wire logic              DTACK_N,
    input  wire logic              BERR_N,
    input  wire logic [DATA_W-1:0] D_IN,
    output logic      [3:1]        A_OUT,
    output logic                   IACK_N,
    output logic                   AS_N,
    output logic                   DS0_N,
    output logic                   DS1_N,
    output logic                   LWORD_N,
    output logic                   WRITE_N,
    output logic                   DTB_OE,
    output logic                   IACK_CHAIN_N
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [7:1]        irq_n_s;
    logic [2:0]        ctl_s;
    logic [DATA_W-1:0] d_s;
    logic              dtack_n_s;
    logic              berr_n_s;
    logic              grant_s;

    iah_sync #(.WIDTH(7), .RST_VAL(7'h7F)) u_sync_irq (
        .clk  (MCLK),
        .rst  (RESET),
        .din  (IRQ_N),
        .dout (irq_n_s)
    );

    iah_sync #(.WIDTH(3), .RST_VAL(3'h3)) u_sync_ctl (
        .clk  (MCLK),
        .rst  (RESET),
        .din  ({BUS_GRANT, BERR_N, DTACK_N}),
        .dout (ctl_s)
    );

    iah_sync #(.WIDTH(DATA_W), .RST_VAL(32'h00000000)) u_sync_data (
        .clk  (MCLK),
        .rst  (RESET),
        .din  (D_IN),
        .dout (d_s)
    );

    assign dtack_n_s = ctl_s[0];
    assign berr_n_s  = ctl_s[1];
    assign grant_s   = ctl_s[2];

    ////////////////////////////////////////////////////////////////////////////////
    // priority pick within the group
    logic [2:0] pick_code;
    logic       pick_valid;

    always_comb begin
        pick_code  = CODE_NONE;
        pick_valid = 1'b0;
        for (int i = 1; i <= NUM_LINES; i++) begin
            if (i >= LINE_LO && i <= LINE_HI && LINE_ENABLE[i] && !irq_n_s[i]) begin
                pick_code  = 3'(i);
                pick_valid = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // acknowledge sequencer
    iah_state_e        state_q,  state_d;
    logic [CNT_W-1:0]  cnt_q,    cnt_d;
    logic [CNT_W-1:0]  tmo_q,    tmo_d;
    logic [2:0]        code_q,   code_d;
    logic [1:0]        wid_q,    wid_d;
    logic              req_q,    req_d;
    logic              done_q,   done_d;
    logic              oe_q,     oe_d;
    logic              iack_q,   iack_d;
    logic              as_q,     as_d;
    logic              ds0_q,    ds0_d;
    logic              ds1_q,    ds1_d;
    logic              lword_q,  lword_d;
    logic              chain_q,  chain_d;
    logic [DATA_W-1:0] sid_q,    sid_d;
    logic [2:0]        lvl_q,    lvl_d;
    logic              valid_q,  valid_d;
    logic              err_q,    err_d;
    logic              acked_q,  acked_d;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        tmo_d   = tmo_q;
        code_d  = code_q;
        wid_d   = wid_q;
        req_d   = req_q;
        done_d  = 1'b0;
        oe_d    = oe_q;
        iack_d  = iack_q;
        as_d    = as_q;
        ds0_d   = ds0_q;
        ds1_d   = ds1_q;
        lword_d = lword_q;
        chain_d = iack_q;
        sid_d   = sid_q;
        lvl_d   = lvl_q;
        valid_d = 1'b0;
        err_d   = 1'b0;
        acked_d = acked_q;
        unique case (state_q)
            IAH_IDLE: begin
                if (pick_valid && !grant_s) begin
                    req_d   = 1'b1;
                    state_d = IAH_REQ;
                end
            end
            IAH_REQ: begin
                // a lost grant race just keeps the request standing
                if (grant_s) begin
                    code_d  = pick_valid ? pick_code : code_q;
                    wid_d   = (READ_WIDTH == WID_QUAD) ? WID_QUAD :
                              (READ_WIDTH == WID_DBL) ? WID_DBL : WID_BYTE;
                    oe_d    = 1'b1;
                    iack_d  = 1'b0;
                    lword_d = (READ_WIDTH != WID_QUAD);
                    cnt_d   = '0;
                    state_d = pick_valid ? IAH_SETUP : IAH_GAP;
                    if (!pick_valid) begin
                        oe_d   = 1'b0;
                        iack_d = 1'b1;
                    end
                end
            end
            IAH_SETUP: begin
                // selection portion: code and acknowledge settle before the strobes
                if (cnt_q >= CNT_W'(ADDR_SETUP_CYC) && dtack_n_s && berr_n_s) begin
                    as_d    = 1'b0;
                    ds0_d   = 1'b0;
                    ds1_d   = (wid_q == WID_BYTE);
                    cnt_d   = '0;
                    tmo_d   = '0;
                    acked_d = 1'b0;
                    state_d = IAH_WAIT_ACK;
                end else begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end
            IAH_WAIT_ACK: begin
                // only the acknowledge or the timeout ends the strobes, never their own order
                if (cnt_q != CNT_W'(AS_LOW_CYC)) begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
                tmo_d = tmo_q + CNT_W'(1);
                if (!dtack_n_s || !berr_n_s) begin
                    acked_d = 1'b1;
                end
                if (tmo_q >= CNT_W'(TIMEOUT_CYC - 1) || !berr_n_s) begin
                    err_d   = 1'b1;
                    lvl_d   = code_q;
                    cnt_d   = '0;
                    state_d = IAH_GAP;
                    as_d    = 1'b1;
                    ds0_d   = 1'b1;
                    ds1_d   = 1'b1;
                    iack_d  = 1'b1;
                end else if (acked_q && cnt_q >= CNT_W'(AS_LOW_CYC)) begin
                    cnt_d   = '0;
                    state_d = IAH_HOLD;
                end
            end
            IAH_HOLD: begin
                // strobes stay low while the Status/ID settles
                cnt_d = cnt_q + CNT_W'(1);
                if (cnt_q >= CNT_W'(DATA_HOLD_CYC)) begin
                    unique case (wid_q)
                        WID_QUAD: sid_d = d_s;
                        WID_DBL:  sid_d = {16'h0000, d_s[15:0]};
                        default:  sid_d = {24'h000000, d_s[7:0]};
                    endcase
                    lvl_d   = code_q;
                    valid_d = 1'b1;
                    as_d    = 1'b1;
                    ds0_d   = 1'b1;
                    ds1_d   = 1'b1;
                    iack_d  = 1'b1;
                    cnt_d   = '0;
                    state_d = IAH_GAP;
                end
            end
            IAH_GAP: begin
                // strobes high long enough before the bus is handed back
                cnt_d = cnt_q + CNT_W'(1);
                if (cnt_q >= CNT_W'(AS_HIGH_CYC)) begin
                    oe_d    = 1'b0;
                    lword_d = 1'b1;
                    req_d   = 1'b0;
                    done_d  = 1'b1;
                    state_d = IAH_IDLE;
                end
            end
            default: state_d = IAH_IDLE;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            state_q <= IAH_IDLE;
            cnt_q   <= '0;
            tmo_q   <= '0;
            code_q  <= CODE_NONE;
            wid_q   <= WID_BYTE;
            req_q   <= 1'b0;
            done_q  <= 1'b0;
            oe_q    <= 1'b0;
            iack_q  <= 1'b1;
            as_q    <= 1'b1;
            ds0_q   <= 1'b1;
            ds1_q   <= 1'b1;
            lword_q <= 1'b1;
            chain_q <= 1'b1;
            sid_q   <= 32'h00000000;
            lvl_q   <= CODE_NONE;
            valid_q <= 1'b0;
            err_q   <= 1'b0;
            acked_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            tmo_q   <= tmo_d;
            code_q  <= code_d;
            wid_q   <= wid_d;
            req_q   <= req_d;
            done_q  <= done_d;
            oe_q    <= oe_d;
            iack_q  <= iack_d;
            as_q    <= as_d;
            ds0_q   <= ds0_d;
            ds1_q   <= ds1_d;
            lword_q <= lword_d;
            chain_q <= chain_d;
            sid_q   <= sid_d;
            lvl_q   <= lvl_d;
            valid_q <= valid_d;
            err_q   <= err_d;
            acked_q <= acked_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign STATUS_ID    = sid_q;
    assign STATUS_LEVEL = lvl_q;
    assign STATUS_VALID = valid_q;
    assign STATUS_ERROR = err_q;
    assign BUS_REQ      = req_q;
    assign BUS_DONE     = done_q;
    assign A_OUT        = code_q;
    assign IACK_N       = iack_q;
    assign AS_N         = as_q;
    assign DS0_N        = ds0_q;
    assign DS1_N        = ds1_q;
    assign LWORD_N      = lword_q;
    assign WRITE_N      = 1'b1 | oe_q;
    assign DTB_OE       = oe_q;
    assign IACK_CHAIN_N = chain_q;

endmodule : iah_handler
`default_nettype wire

/* File: verification/iah_handler_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module iah_handler_sva
    import iah_pkg::*;
(
    input wire logic       MCLK,
    input wire logic       RESET,
    input wire logic [1:0] READ_WIDTH,
    input wire logic       BUS_REQ,
    input wire logic       BUS_GRANT,
    input wire logic       BUS_DONE,
    input wire logic       DTACK_N,
    input wire logic       BERR_N,
    input wire logic [3:1] A_OUT,
    input wire logic       IACK_N,
    input wire logic       AS_N,
    input wire logic       DS0_N,
    input wire logic       DS1_N,
    input wire logic       LWORD_N,
    input wire logic       DTB_OE,
    input wire logic       IACK_CHAIN_N,
    input wire logic       STATUS_VALID
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    chain_start_a: assert property (IACK_CHAIN_N == $past(IACK_N))
        else $error("chain start not one cycle behind acknowledge");
    grant_first_a: assert property ($fell(IACK_N) |-> BUS_REQ && $past(BUS_GRANT, 2))
        else $error("acknowledge driven without grant");
    addr_setup_a: assert property ($fell(AS_N) |->
        $past(IACK_N, 7) == 1'b0 && A_OUT != CODE_NONE) else $error("address strobe too early");
    code_hold_a: assert property (!IACK_N && $past(IACK_N) == 1'b0 |->
        $stable(A_OUT) && $stable(LWORD_N)) else $error("code changed in cycle");
    strobe_fall_a: assert property ($fell(DS0_N) |->
        $fell(AS_N) && $past(DTACK_N, 3) && $past(BERR_N, 3)) else $error("bad strobe start");
    width_a: assert property (!DS0_N |-> LWORD_N == (READ_WIDTH != WID_QUAD) &&
        DS1_N == (READ_WIDTH != WID_DBL && READ_WIDTH != WID_QUAD)) else $error("width lines");
    strobe_rise_a: assert property ($rose(AS_N) |-> $rose(DS0_N) &&
        ($past(DTACK_N, 2) == 1'b0 || $past(BERR_N, 2) == 1'b0)) else $error("early release");
    valid_ack_a: assert property (STATUS_VALID |->
        $rose(AS_N) && $past(DTACK_N, 2) == 1'b0) else $error("valid without answer");
    bus_done_a: assert property (BUS_DONE |->
        !BUS_REQ && $past(BUS_REQ) && !DTB_OE && IACK_N) else $error("bus released badly");
endmodule : iah_handler_sva
bind iah_handler iah_handler_sva u_sva (.MCLK(MCLK), .RESET(RESET), .READ_WIDTH(READ_WIDTH),
    .BUS_REQ(BUS_REQ), .BUS_GRANT(BUS_GRANT), .BUS_DONE(BUS_DONE), .DTACK_N(DTACK_N),
    .BERR_N(BERR_N), .A_OUT(A_OUT), .IACK_N(IACK_N), .AS_N(AS_N), .DS0_N(DS0_N),
    .DS1_N(DS1_N), .LWORD_N(LWORD_N), .DTB_OE(DTB_OE), .IACK_CHAIN_N(IACK_CHAIN_N),
    .STATUS_VALID(STATUS_VALID));
`default_nettype wire

/* File: verification/iah_intr_model.sv */
`timescale 1ns/10ps
`default_nettype none
module iah_intr_model
    import iah_pkg::*;
#(
    parameter logic [31:0] ID_A = 32'h0,
    parameter logic [31:0] ID_B = 32'h0
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [2:0] lvl_a,
    input  wire logic [2:0] lvl_b,
    input  wire logic       raise_a,
    input  wire logic       raise_b,
    input  wire logic       fault,
    input  wire logic       bus_req,
    input  wire logic       bus_done,
    output logic            bus_grant,
    input  wire logic [3:1] a_out,
    input  wire logic       iack_in_n,
    input  wire logic       ds0_n,
    input  wire logic       ds1_n,
    input  wire logic       lword_n,
    output logic     [7:1]  irq_n,
    output logic            dtack_n,
    output logic            berr_n,
    output logic     [31:0] d_in
);
    logic        pend_a, pend_b, sel_a, sel_b, ack_q, ack_qq, gnt_q, rel;
    logic [4:0]  cnt;
    logic [31:0] id;
    ////////////////////////////////////////////////////////////
    // requester, request lines, two interrupters in chain order a then b
    assign bus_grant = gnt_q && bus_req;
    assign id = sel_a ? ID_A : ID_B;
    assign rel = ds0_n && ds1_n && cnt != 5'h00;
    always_comb begin
        for (int l = 1; l <= 7; l++) begin
            irq_n[l] = !(pend_a && lvl_a == 3'(l) || pend_b && lvl_b == 3'(l));
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            {pend_a, pend_b, sel_a, sel_b, gnt_q, cnt} <= '0;
            {ack_q, ack_qq, dtack_n, berr_n, d_in} <= '1;
        end else begin
            gnt_q <= bus_req && !bus_done;
            {ack_q, ack_qq} <= {iack_in_n, ack_q};
            pend_a <= (pend_a || raise_a) && !(sel_a && rel);
            pend_b <= (pend_b || raise_b) && !(sel_b && rel);
            if (ack_qq && !ack_q) begin
                sel_a <= pend_a && lvl_a == a_out;
                sel_b <= !(pend_a && lvl_a == a_out) && pend_b && lvl_b == a_out;
            end
            if (rel) begin
                {sel_a, sel_b, cnt} <= '0;
                {dtack_n, berr_n, d_in} <= '1;
            end else if ((sel_a || sel_b) && (!ds0_n || !ds1_n)) begin
                if (cnt < (sel_b ? 5'h14 : 5'h01)) begin
                    cnt <= cnt + 5'h01;
                end else begin
                    {dtack_n, berr_n} <= {fault, !fault};
                    d_in <= !lword_n ? id : {16'hFFFF, id[15:8] | {8{ds1_n}}, id[7:0]};
                end
            end
        end
    end
endmodule : iah_intr_model
`default_nettype wire

/* File: verification/test_interrupt_ack_daisy_chain.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("CHECK FAILED %0t %s", $time, msg); end end
module test_interrupt_ack_daisy_chain
    import iah_pkg::*;
;
    typedef struct packed {
        logic [7:1] en;
        logic [1:0] wid;
        logic [2:0] la;
        logic [2:0] lb;
        logic       ra;
        logic       rb;
        logic [2:0] lvl;
        logic       sb;
    } iah_row_s;
    localparam logic [31:0] ID_A = 32'hA1B2C3D4;
    localparam logic [31:0] ID_B = 32'h5E6F7081;
    localparam iah_row_s ROWS [8] = '{
        {7'h7F, WID_BYTE, 3'h3, 3'h1, 1'b1, 1'b0, 3'h3, 1'b0},
        {7'h7F, WID_DBL, 3'h3, 3'h6, 1'b0, 1'b1, 3'h6, 1'b1},
        {7'h7F, WID_QUAD, 3'h5, 3'h5, 1'b1, 1'b1, 3'h5, 1'b0},
        {7'h7F, WID_QUAD, 3'h5, 3'h5, 1'b0, 1'b0, 3'h5, 1'b1},
        {7'h7F, WID_BYTE, 3'h2, 3'h7, 1'b1, 1'b1, 3'h7, 1'b1},
        {7'h7F, WID_DBL, 3'h2, 3'h7, 1'b0, 1'b0, 3'h2, 1'b0},
        {7'h5F, 2'h3, 3'h4, 3'h6, 1'b1, 1'b1, 3'h4, 1'b0},
        {7'h7F, WID_QUAD, 3'h4, 3'h6, 1'b0, 1'b0, 3'h6, 1'b1}};
    logic        mclk = 1'b0, reset = 1'b1, raise_a = 1'b0, raise_b = 1'b0, fault = 1'b0;
    logic [7:1]  line_enable = 7'h7F, irq_n;
    logic [1:0]  read_width = 2'h0;
    logic [2:0]  lvl_a = 3'h1, lvl_b = 3'h2, status_level;
    logic [31:0] status_id, d_in;
    logic [3:1]  a_out;
    logic        status_valid, status_error, bus_req, bus_grant, bus_done, dtack_n, berr_n;
    logic        iack_n, as_n, ds0_n, ds1_n, lword_n, dtb_oe, iack_chain_n, write_n;
    int          error_cnt = 0, checks = 0;
    always #2.5 mclk = ~mclk;
    iah_handler #(.TIMEOUT_CYC(50)) DUT (
        .MCLK(mclk), .RESET(reset), .LINE_ENABLE(line_enable), .READ_WIDTH(read_width),
        .STATUS_ID(status_id), .STATUS_LEVEL(status_level), .STATUS_VALID(status_valid),
        .STATUS_ERROR(status_error), .BUS_REQ(bus_req), .BUS_GRANT(bus_grant),
        .BUS_DONE(bus_done), .IRQ_N(irq_n), .DTACK_N(dtack_n), .BERR_N(berr_n), .D_IN(d_in),
        .A_OUT(a_out), .IACK_N(iack_n), .AS_N(as_n), .DS0_N(ds0_n), .DS1_N(ds1_n),
        .LWORD_N(lword_n), .WRITE_N(write_n), .DTB_OE(dtb_oe), .IACK_CHAIN_N(iack_chain_n));
    iah_intr_model #(.ID_A(ID_A), .ID_B(ID_B)) u_model (
        .clk(mclk), .rst(reset), .lvl_a(lvl_a), .lvl_b(lvl_b), .raise_a(raise_a),
        .raise_b(raise_b), .fault(fault), .bus_req(bus_req), .bus_done(bus_done),
        .bus_grant(bus_grant), .a_out(a_out), .iack_in_n(iack_chain_n), .ds0_n(ds0_n),
        .ds1_n(ds1_n), .lword_n(lword_n), .irq_n(irq_n), .dtack_n(dtack_n), .berr_n(berr_n),
        .d_in(d_in));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] exp_id(input logic [31:0] id, input logic [1:0] w);
        return (w == WID_QUAD) ? id : (w == WID_DBL) ? {16'h0, id[15:0]} : {24'h0, id[7:0]};
    endfunction : exp_id
    task automatic wait_pulse(input logic err);
        int n;
        for (n = 0; n < 600 && (err ? status_error : status_valid) !== 1'b1; n++) @(negedge mclk);
        `CHK(n < 600, 1'b1, "no completion pulse")
    endtask : wait_pulse
    task automatic check_idle;
        @(negedge mclk);
        `CHK(iack_chain_n, 1'b1, "chain start busy")
        `CHK({iack_n, as_n, bus_req, dtb_oe}, 4'hC, "handler not idle")
    endtask : check_idle
    task automatic results;
        $display("mismatches %0d comparisons %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        #(CLK_PERIOD_NS * 20000);
        error_cnt++;
        results();
    end
    initial begin
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        check_idle();
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            {line_enable, read_width, lvl_a, lvl_b, raise_a, raise_b} <= ROWS[i][20:4];
            @(posedge mclk);
            {raise_a, raise_b} <= 2'h0;
            wait_pulse(1'b0);
            `CHK(status_level, ROWS[i].lvl, "line number")
            `CHK(status_id, exp_id(ROWS[i].sb ? ID_B : ID_A, ROWS[i].wid), "status id")
        end
        // bus error ends the cycle without data
        @(posedge mclk);
        {fault, lvl_a, raise_a} <= {1'b1, 3'h1, 1'b1};
        @(posedge mclk);
        raise_a <= 1'b0;
        wait_pulse(1'b1);
        `CHK({status_level, status_valid}, 4'h2, "error cycle")
        // reset in the middle of a slow read
        @(posedge mclk);
        {fault, lvl_b, raise_b} <= {1'b0, 3'h4, 1'b1};
        @(posedge mclk);
        raise_b <= 1'b0;
        for (int n = 0; n < 300 && as_n !== 1'b0; n++) @(negedge mclk);
        `CHK(as_n, 1'b0, "no address strobe")
        `CHK({write_n, lword_n, ds1_n}, 3'h4, "quad read lines")
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        check_idle();
        results();
    end
endmodule : test_interrupt_ack_daisy_chain
`default_nettype wire
